// file: core/rcr_pkg.sv
/*
 * rcr_pkg: register map, field positions, reset values and lookup tables
 * for the rail control register bank of converter cores 1 to 3.
 * Assumes byte-wide registers reached through the device's serial register port.
 */
package rcr_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RAIL_N = 3;

   // ==========================================================
   // register offsets
   localparam logic [7:0] RAIL1_CONTROL_A = 8'h04;
   localparam logic [7:0] RAIL1_CONTROL_B = 8'h05;
   localparam logic [7:0] RAIL2_CONTROL_A = 8'h06;
   localparam logic [7:0] RAIL2_CONTROL_B = 8'h07;
   localparam logic [7:0] RAIL3_CONTROL_A = 8'h08;

   // ==========================================================
   // control a fields
   localparam int CORE_ENABLE_BIT = 7;
   localparam int PIN_GATING_BIT = 6;
   localparam int PIN_CHOICE_BIT = 5;
   localparam int LEVEL_MODE_BIT = 4;
   localparam int DISCHARGE_BIT = 3;
   localparam int FORCED_PWM_BIT = 1;

   // ==========================================================
   // control b fields
   localparam int LIMIT_LSB = 3;
   localparam int LIMIT_MSB = 5;
   localparam int RAMP_LSB = 0;
   localparam int RAMP_MSB = 2;

   // ==========================================================
   // reset values
   localparam logic [7:0] CONTROL_A_RESET = 8'hca;
   localparam logic [7:0] RAIL1_CONTROL_B_RESET = 8'h1a;
   localparam logic [7:0] RAIL2_CONTROL_B_RESET = 8'h1a;
   localparam logic [7:0] RAIL3_CONTROL_B_RESET = 8'h2a;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================================
   // current limit: code 2 is 2.5 A, half-amp steps up to code 7
   localparam logic [2:0] LIMIT_MIN_CODE = 3'h2;
   localparam logic [3:0] LIMIT_CODE_TO_HALF_AMP = 4'h3;
   localparam logic [3:0] LIMIT_FLOOR_HALF_AMP = 4'h5;

   // ramp rate per code, in units of 0.01 mV/us
   localparam logic [11:0] RAMP_RATE_CENTI [0:7] = '{
      12'hbb8, 12'h5dc, 12'h3e8, 12'h2ee, 12'h17c, 12'h0be, 12'h05e, 12'h028
   };

   typedef logic [2:0] rcr_code_t;

endpackage : rcr_pkg

// file: core/rcr_rail_if.sv
/*
 * rcr_rail_if: write path and stored control bytes of one rail.
 * Assumes the decoder and the rail store share sys_clk.
 */
`timescale 1ns/100ps
interface rcr_rail_if;
   logic [7:0] wrData;
   logic wrA;
   logic wrB;
   logic [7:0] ctrlA;
   logic [7:0] ctrlB;

   modport decoder (
      output wrData,
      output wrA,
      output wrB,
      input ctrlA,
      input ctrlB
   );

   modport store (
      input wrData,
      input wrA,
      input wrB,
      output ctrlA,
      output ctrlB
   );
endinterface : rcr_rail_if

// file: core/rcr_rail_regs.sv
/*
 * rcr_rail_regs: the two control bytes of one rail.
 * Assumes write strobes are one-cycle pulses decoded by the top module.
 */
`timescale 1ns/100ps
module rcr_rail_regs
   import rcr_pkg::*;
#(
   parameter bit HAS_CTRL_B = 1'b1,
   parameter logic [7:0] CTRL_B_RESET = RAIL1_CONTROL_B_RESET
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register access
   rcr_rail_if.store bus
);

   logic [7:0] ctrlAReg;
   logic [7:0] ctrlANext;
   logic [7:0] ctrlBReg;
   logic [7:0] ctrlBNext;

   // ==========================================================
   // storage
   always_comb begin
      ctrlANext = ctrlAReg;
      ctrlBNext = ctrlBReg;
      // R8: writes taken any time
      // R11: reserved bits kept as written
      if (bus.wrA) begin
         ctrlANext = bus.wrData;
      end
      if (bus.wrB && HAS_CTRL_B) begin
         ctrlBNext = bus.wrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrlAReg <= CONTROL_A_RESET;
         ctrlBReg <= CTRL_B_RESET;
      end else begin
         ctrlAReg <= ctrlANext;
         ctrlBReg <= ctrlBNext;
      end
   end

   assign bus.ctrlA = ctrlAReg;
   assign bus.ctrlB = ctrlBReg;

   // ==========================================================
   // checks
   a_write_a_lands: assert property ( // R11
      @(posedge sys_clk) disable iff (reset)
      bus.wrA |=> bus.ctrlA == $past(bus.wrData))
      else $error("control a write not stored");

   a_write_b_lands: assert property ( // R8
      @(posedge sys_clk) disable iff (reset)
      (bus.wrB && HAS_CTRL_B) |=> bus.ctrlB == $past(bus.wrData))
      else $error("control b write not stored");

   a_b_fixed: assert property ( // R12
      @(posedge sys_clk) disable iff (reset)
      !HAS_CTRL_B |-> bus.ctrlB == CTRL_B_RESET)
      else $error("absent control b changed");

endmodule : rcr_rail_regs

// file: core/rcr_rail_control.sv
/*
 * rcr_rail_control: control register bank and rail steering for converter
 * cores 1 to 3. Holds control a/b of cores 1 and 2 and control a of core 3.
 * Assumes the serial interface presents byte accesses on the register port,
 * synchronous to sys_clk, and the enable pins are already synchronous.
 */
// Overview of operation
// R1: a core runs when its enable bit (bit 7 of control a) is set and stops when it is clear.
// R2: with pin gating (bit 6) clear only the enable bit counts, else enable and pin must both hold.
// R3: under pin gating the pin-choice bit (bit 5) picks pin a when 0 and pin b when 1.
// R4: the level-mode bit (bit 4) turns the pin from on/off control into high/low level choice.
// R5: the discharge resistor is connected while the core is off only if bit 3 is set.
// R6: bit 1 forces continuous PWM when set, else the core moves between PFM and PWM itself.
// R7: current-limit code 2 gives 2.5 A, rising by 0.5 A per code up to 5.0 A at code 7.
// R8: current-limit writes are accepted and applied while the core runs.
// R9: the ramp-rate code sets rising and falling slew from 30 down to 0.4 mV/us.
// R10: a core at its low level is regulated to its own low-level voltage setting.
// R11: reserved bits reset to zero and read back as written; limit codes 0 and 1 are harmless.
// R12: every core has its own fields and a write to one core leaves the others alone.
`timescale 1ns/100ps
module rcr_rail_control
   import rcr_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port from the serial interface
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [DATA_W-1:0] regRdData,
   output logic regRdValid,
   // enable pins
   input wire logic enablePinA,
   input wire logic enablePinB,
   // per-rail controls, index 0 is core 1
   output logic [RAIL_N-1:0] coreOn,
   output logic [RAIL_N-1:0] lowLevelSelect,
   output logic [RAIL_N-1:0] dischargeOn,
   output logic [RAIL_N-1:0] forcedPwm,
   output logic [RAIL_N-1:0][2:0] switchLimitCode,
   output logic [RAIL_N-1:0][3:0] switchLimitHalfAmp,
   output logic [RAIL_N-1:0][2:0] rampRateCode,
   output logic [RAIL_N-1:0][11:0] rampRateCenti
);

   // ==========================================================
   // address decode
   logic [RAIL_N-1:0] hitA;
   logic [RAIL_N-1:0] hitB;
   logic [RAIL_N-1:0][7:0] railCtrlA;
   logic [RAIL_N-1:0][7:0] railCtrlB;

   always_comb begin
      hitA = '0;
      hitB = '0;
      // R12: one register, one rail
      unique case (regAddr)
         RAIL1_CONTROL_A: hitA[0] = 1'b1;
         RAIL1_CONTROL_B: hitB[0] = 1'b1;
         RAIL2_CONTROL_A: hitA[1] = 1'b1;
         RAIL2_CONTROL_B: hitB[1] = 1'b1;
         RAIL3_CONTROL_A: hitA[2] = 1'b1;
         default: begin
            hitA = '0;
            hitB = '0;
         end
      endcase
   end

   // ==========================================================
   // rail stores
   rcr_rail_if railBus [RAIL_N] ();

   genvar g;
   generate
      for (g = 0; g < RAIL_N; g++) begin : gen_store
         localparam logic [7:0] B_RESET = (g == 0) ? RAIL1_CONTROL_B_RESET :
                                          (g == 1) ? RAIL2_CONTROL_B_RESET :
                                                     RAIL3_CONTROL_B_RESET;
         assign railBus[g].wrData = regWrData;
         assign railBus[g].wrA = regWrEn && hitA[g];
         assign railBus[g].wrB = regWrEn && hitB[g];
         assign railCtrlA[g] = railBus[g].ctrlA;
         assign railCtrlB[g] = railBus[g].ctrlB;

         rcr_rail_regs #(
            .HAS_CTRL_B((g < 2) ? 1'b1 : 1'b0),
            .CTRL_B_RESET(B_RESET)
         ) u_regs (
            .sys_clk(sys_clk),
            .reset(reset),
            .bus(railBus[g])
         );
      end
   endgenerate

   // ==========================================================
   // read path
   logic [DATA_W-1:0] rdDataReg;
   logic [DATA_W-1:0] rdDataNext;
   logic rdValidReg;
   logic rdValidNext;

   always_comb begin
      rdDataNext = rdDataReg;
      rdValidNext = regRdEn;
      if (regRdEn) begin
         rdDataNext = UNMAPPED_READ;
         for (int i = 0; i < RAIL_N; i++) begin
            if (hitA[i]) begin
               rdDataNext = railCtrlA[i];
            end
            if (hitB[i]) begin
               rdDataNext = railCtrlB[i];
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdDataReg <= UNMAPPED_READ;
         rdValidReg <= 1'b0;
      end else begin
         rdDataReg <= rdDataNext;
         rdValidReg <= rdValidNext;
      end
   end

   assign regRdData = rdDataReg;
   assign regRdValid = rdValidReg;

   // ==========================================================
   // rail steering
   logic [RAIL_N-1:0] selPin;
   logic [RAIL_N-1:0] onNext;
   logic [RAIL_N-1:0] lowNext;
   logic [RAIL_N-1:0] dischNext;
   logic [RAIL_N-1:0] pwmNext;
   logic [RAIL_N-1:0][3:0] halfAmpNext;
   logic [RAIL_N-1:0] onReg;
   logic [RAIL_N-1:0] lowReg;
   logic [RAIL_N-1:0] dischReg;
   logic [RAIL_N-1:0] pwmReg;
   logic [RAIL_N-1:0][2:0] limitReg;
   logic [RAIL_N-1:0][3:0] halfAmpReg;
   logic [RAIL_N-1:0][2:0] rampReg;
   logic [RAIL_N-1:0][11:0] rampCentiReg;

   always_comb begin
      for (int i = 0; i < RAIL_N; i++) begin
         // R3: pin choice
         selPin[i] = railCtrlA[i][PIN_CHOICE_BIT] ? enablePinB : enablePinA;
         // R1: enable bit
         // R2: pin gating
         // R4: level mode keeps core on, pin picks level
         onNext[i] = railCtrlA[i][CORE_ENABLE_BIT] && (!railCtrlA[i][PIN_GATING_BIT]
                     || railCtrlA[i][LEVEL_MODE_BIT] || selPin[i]);
         // R10: low level selected by pin low
         lowNext[i] = onNext[i] && railCtrlA[i][PIN_GATING_BIT]
                      && railCtrlA[i][LEVEL_MODE_BIT] && !selPin[i];
         // R5: discharge only while off
         dischNext[i] = !onNext[i] && railCtrlA[i][DISCHARGE_BIT];
         // R6: forced pwm
         pwmNext[i] = railCtrlA[i][FORCED_PWM_BIT];
         // R7: limit decode
         // R11: codes 0 and 1 held at the lowest limit
         if (railCtrlB[i][LIMIT_MSB:LIMIT_LSB] < LIMIT_MIN_CODE) begin
            halfAmpNext[i] = LIMIT_FLOOR_HALF_AMP;
         end else begin
            halfAmpNext[i] = 4'({1'b0, railCtrlB[i][LIMIT_MSB:LIMIT_LSB]})
                             + LIMIT_CODE_TO_HALF_AMP;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         onReg <= '0;
         lowReg <= '0;
         dischReg <= '0;
         pwmReg <= '0;
         limitReg <= '0;
         halfAmpReg <= '0;
         rampReg <= '0;
         rampCentiReg <= '0;
      end else begin
         onReg <= onNext;
         lowReg <= lowNext;
         dischReg <= dischNext;
         pwmReg <= pwmNext;
         for (int i = 0; i < RAIL_N; i++) begin
            // R8: new limit applied while running
            limitReg[i] <= railCtrlB[i][LIMIT_MSB:LIMIT_LSB];
            halfAmpReg[i] <= halfAmpNext[i];
            // R9: ramp rate table
            rampReg[i] <= railCtrlB[i][RAMP_MSB:RAMP_LSB];
            rampCentiReg[i] <= RAMP_RATE_CENTI[railCtrlB[i][RAMP_MSB:RAMP_LSB]];
         end
      end
   end

   assign coreOn = onReg;
   assign lowLevelSelect = lowReg;
   assign dischargeOn = dischReg;
   assign forcedPwm = pwmReg;
   assign switchLimitCode = limitReg;
   assign switchLimitHalfAmp = halfAmpReg;
   assign rampRateCode = rampReg;
   assign rampRateCenti = rampCentiReg;

   // ==========================================================
   // checks
   sequence s_write_a(int r);
      regWrEn && hitA[r];
   endsequence

   generate
      for (g = 0; g < RAIL_N; g++) begin : gen_chk
         a_enable_off: assert property ( // R1
            @(posedge sys_clk) disable iff (reset)
            !railCtrlA[g][CORE_ENABLE_BIT] |=> !coreOn[g])
            else $error("core on with enable bit clear");

         a_ungated_on: assert property ( // R2
            @(posedge sys_clk) disable iff (reset)
            (railCtrlA[g][CORE_ENABLE_BIT] && !railCtrlA[g][PIN_GATING_BIT])
            |=> coreOn[g])
            else $error("ungated core not on");

         a_gated_pin_a: assert property ( // R3
            @(posedge sys_clk) disable iff (reset)
            (railCtrlA[g][7:4] == 4'hc && !enablePinA) |=> !coreOn[g])
            else $error("pin a does not gate core");

         a_gated_pin_b: assert property ( // R3
            @(posedge sys_clk) disable iff (reset)
            (railCtrlA[g][7:4] == 4'he) |=> coreOn[g] == $past(enablePinB))
            else $error("pin b does not gate core");

         a_level_mode: assert property ( // R4
            @(posedge sys_clk) disable iff (reset)
            (railCtrlA[g][CORE_ENABLE_BIT] && railCtrlA[g][PIN_GATING_BIT]
             && railCtrlA[g][LEVEL_MODE_BIT])
            |=> coreOn[g] && lowLevelSelect[g] == !$past(selPin[g]))
            else $error("level mode wrong");

         a_low_needs_on: assert property ( // R10
            @(posedge sys_clk) disable iff (reset)
            lowLevelSelect[g] |-> coreOn[g])
            else $error("low level while off");

         a_discharge: assert property ( // R5
            @(posedge sys_clk) disable iff (reset)
            1'b1 |=> dischargeOn[g] == (!coreOn[g] && $past(railCtrlA[g][DISCHARGE_BIT])))
            else $error("discharge state wrong");

         a_pwm_mode: assert property ( // R6
            @(posedge sys_clk) disable iff (reset)
            s_write_a(g) ##1 1'b1 |=> forcedPwm[g] == $past(regWrData[FORCED_PWM_BIT], 2))
            else $error("forced pwm not applied");

         a_limit_map: assert property ( // R7
            @(posedge sys_clk) disable iff (reset)
            switchLimitCode[g] >= LIMIT_MIN_CODE
            |-> switchLimitHalfAmp[g] == 4'(switchLimitCode[g]) + 4'h3)
            else $error("limit decode wrong");

         a_ramp_map: assert property ( // R9
            @(posedge sys_clk) disable iff (reset)
            rampRateCode[g] == 3'h3 |-> rampRateCenti[g] == 12'h2ee)
            else $error("ramp decode wrong");
      end
   endgenerate

   a_live_limit: assert property ( // R8
      @(posedge sys_clk) disable iff (reset)
      (regWrEn && hitB[0] && coreOn[0]) ##2 1'b1
      |-> switchLimitCode[0] == $past(regWrData[LIMIT_MSB:LIMIT_LSB], 2))
      else $error("limit not applied while running");

   a_isolated_write: assert property ( // R12
      @(posedge sys_clk) disable iff (reset)
      (regWrEn && hitA[0]) |=> $stable(railCtrlA[1]) && $stable(railCtrlA[2]))
      else $error("write leaked to another rail");

   a_readback: assert property ( // R11
      @(posedge sys_clk) disable iff (reset)
      (regRdEn && hitA[1]) |=> regRdValid && regRdData == $past(railCtrlA[1]))
      else $error("read data wrong");

   a_unmapped_zero: assert property ( // R11
      @(posedge sys_clk) disable iff (reset)
      (regRdEn && hitA == '0 && hitB == '0) |=> regRdData == UNMAPPED_READ)
      else $error("unmapped read not zero");

endmodule : rcr_rail_control

// file: testbench/rcr_host_model.sv
/*
 * rcr_host_model: register-port master standing in for the serial host.
 * Assumes one bench process calls its tasks, after reset has been released.
 */
`timescale 1ns/100ps
module rcr_host_model
   import rcr_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // register port
   output logic [ADDR_W-1:0] regAddr,
   output logic [DATA_W-1:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic regRdValid
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end

   // ==========================================================
   // byte write, strobe held for one rising edge
   task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      regAddr = addr;
      regWrData = data;
      regWrEn = 1'b1;
      @(negedge sys_clk);
      regWrEn = 1'b0;
      // released lines must not keep showing the last value
      regAddr = ~addr;
      regWrData = ~data;
   endtask : writeReg

   // ==========================================================
   // byte read, answer taken at the falling edge half a cycle after the read edge
   task automatic readReg(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
      @(negedge sys_clk);
      regAddr = addr;
      regRdEn = 1'b1;
      @(negedge sys_clk);
      regRdEn = 1'b0;
      regAddr = ~addr;
      data = regRdData;
      valid = regRdValid;
   endtask : readReg
endmodule : rcr_host_model

// file: testbench/tb_top.sv
/*
 * tb_top: self-checking bench for the rail control register bank.
 * Assumes the host model drives the register port; pins change at falling edges.
 */
`timescale 1ns/100ps
module tb_top
   import rcr_pkg::*;
;
   logic sys_clk;
   logic reset;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData;
   logic regWrEn;
   logic regRdEn;
   logic [DATA_W-1:0] regRdData;
   logic regRdValid;
   logic enablePinA;
   logic enablePinB;
   logic [RAIL_N-1:0] coreOn;
   logic [RAIL_N-1:0] lowLevelSelect;
   logic [RAIL_N-1:0] dischargeOn;
   logic [RAIL_N-1:0] forcedPwm;
   logic [RAIL_N-1:0][2:0] switchLimitCode;
   logic [RAIL_N-1:0][3:0] switchLimitHalfAmp;
   logic [RAIL_N-1:0][2:0] rampRateCode;
   logic [RAIL_N-1:0][11:0] rampRateCenti;
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 32'h7011c236;
   logic [7:0] ctrlA [0:2];
   logic [7:0] ctrlB [0:2];
   logic [7:0] rdData;
   logic rdValid;
   localparam logic [7:0] ADDR_A [0:2] = '{RAIL1_CONTROL_A, RAIL2_CONTROL_A, RAIL3_CONTROL_A};

   rcr_rail_control i_rcr_rail_control (.sys_clk, .reset, .regAddr, .regWrData, .regWrEn,
      .regRdEn, .regRdData, .regRdValid, .enablePinA, .enablePinB, .coreOn, .lowLevelSelect,
      .dischargeOn, .forcedPwm, .switchLimitCode, .switchLimitHalfAmp, .rampRateCode,
      .rampRateCenti);

   rcr_host_model host (.sys_clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
      .regRdValid);

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // expectations
   function automatic logic expOn(input logic [7:0] a, input logic pin);
      return a[7] & (~a[6] | a[4] | pin);
   endfunction : expOn

   function automatic logic [3:0] expHalfAmp(input logic [2:0] code);
      return (code < 3'h2) ? 4'h5 : {1'b0, code} + 4'h3;
   endfunction : expHalfAmp

   function automatic logic [11:0] expCenti(input logic [2:0] code);
      logic [11:0] rate [0:7];
      rate = '{12'hbb8, 12'h5dc, 12'h3e8, 12'h2ee, 12'h17c, 12'h0be, 12'h05e, 12'h028};
      return rate[code];
   endfunction : expCenti

   // ==========================================================
   // comparison and run end
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   task automatic compareRails();
      logic [7:0] a;
      logic [7:0] b;
      logic pin;
      logic on;
      for (int r = 0; r < RAIL_N; r++) begin
         a = ctrlA[r];
         b = ctrlB[r];
         pin = a[5] ? enablePinB : enablePinA;
         on = expOn(a, pin);
         check("coreOn", 12'(coreOn[r]), 12'(on));
         check("lowLevelSelect", 12'(lowLevelSelect[r]), 12'(a[7] & a[6] & a[4] & ~pin));
         check("dischargeOn", 12'(dischargeOn[r]), 12'(~on & a[3]));
         check("forcedPwm", 12'(forcedPwm[r]), 12'(a[1]));
         check("switchLimitCode", 12'(switchLimitCode[r]), 12'(b[5:3]));
         check("switchLimitHalfAmp", 12'(switchLimitHalfAmp[r]), 12'(expHalfAmp(b[5:3])));
         check("rampRateCode", 12'(rampRateCode[r]), 12'(b[2:0]));
         check("rampRateCenti", rampRateCenti[r], expCenti(b[2:0]));
      end
      check("readValidIdle", 12'(regRdValid), 12'h000);
   endtask : compareRails

   // ==========================================================
   // register access
   task automatic writeCtrl(input int r, input bit isB, input logic [7:0] d);
      host.writeReg(isB ? ADDR_A[r] + 8'h01 : ADDR_A[r], d);
      // rail 3 has no control b here, so that write must be ignored
      if (isB && r < 2) ctrlB[r] = d;
      else if (!isB) ctrlA[r] = d;
      @(negedge sys_clk);
      compareRails();
   endtask : writeCtrl

   task automatic readAll();
      logic [7:0] bad [0:2];
      bad = '{8'h03, 8'h09, 8'hff};
      for (int r = 0; r < RAIL_N; r++) begin
         host.readReg(ADDR_A[r], rdData, rdValid);
         check("readValid", 12'(rdValid), 12'h001);
         check("controlA", 12'(rdData), 12'(ctrlA[r]));
         if (r < 2) begin
            host.readReg(ADDR_A[r] + 8'h01, rdData, rdValid);
            check("controlB", 12'(rdData), 12'(ctrlB[r]));
         end
      end
      for (int k = 0; k < 3; k++) begin
         host.writeReg(bad[k], 8'hff);
         host.readReg(bad[k], rdData, rdValid);
         check("unmappedRead", 12'({rdValid, rdData}), 12'h100);
      end
      @(negedge sys_clk);
      compareRails();
   endtask : readAll

   task automatic resetRun();
      reset = 1'b1;
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      ctrlA = '{8'hca, 8'hca, 8'hca};
      ctrlB = '{8'h1a, 8'h1a, 8'h2a};
      @(negedge sys_clk);
      compareRails();
      readAll();
   endtask : resetRun

   // ==========================================================
   // watchdog
   initial begin
      repeat (30000) @(posedge sys_clk);
      fail_count++;
      close_out();
   end

   // ==========================================================
   // main sequence
   initial begin
      int r;
      reset = 1'b1;
      enablePinA = 1'b0;
      enablePinB = 1'b0;
      resetRun();
      // pin walk, one cycle from pin to core
      writeCtrl(0, 1'b0, 8'hc8);
      @(negedge sys_clk);
      enablePinA = 1'b1;
      @(negedge sys_clk);
      compareRails();
      // every gating combination on rail 2
      for (int n = 0; n < 16; n++) begin
         for (int p = 0; p < 4; p++) begin
            enablePinA = p[0];
            enablePinB = p[1];
            writeCtrl(1, 1'b0, {n[3:0], 4'h8});
         end
      end
      for (int i = 0; i < 300; i++) begin
         r = $unsigned($random(seed)) % 3;
         enablePinA = $random(seed);
         enablePinB = $random(seed);
         writeCtrl(r, $random(seed), $random(seed));
         if (i % 20 == 19) readAll();
      end
      resetRun();
      close_out();
   end
endmodule : tb_top
